//--- hdl/link_mode_pkg.sv
// Package with register map, field layout and reset values for the link mode registers
// Behaviour
// - Capability bits 15 and 14 read zero: no 1000BASE-X duplex support; read-only.
// - Capability bits 13 and 12 read one: 1000BASE-T full and half duplex; read-only.
// - Link control 9:8 pick attempts before speed drop: 7,5,4,3; reset 00.
// - Link control 5:4 pick idle error threshold 1e-8..1e-11; reset 10.
// - Link control bit 3 enables link break on threshold; reset clear.
// - Link control bit 2 set disables automatic power optimization.
// - Writing 1 to link control bit 0 issues synchronous logic reset; registers untouched.
// - Mode bit 15 selects normal or short energy detect.
// - Mode bit 14 set enables 10BASE-T fast test mode.
// - Mode bit 13 enables energy detect power-down.
// - Mode bit 12 selects power-down with or without link pulses.
// - Mode bit 7 enables the speed optimizer.
// - Mode bit 6 allows next-page exchange; resets to 1.
// - Mode bit 5 set disables automatic crossover.
package link_mode_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  // Register indices
  localparam logic [4:0] IDX_CAPABILITY = 5'h0f;
  localparam logic [4:0] IDX_LINK_TUNING = 5'h10;
  localparam logic [4:0] IDX_FE_MODE = 5'h11;
  // Capability value
  localparam logic [15:0] CAPABILITY_VALUE = 16'h3000;
  // Link tuning field positions
  localparam int LT_ATTEMPT_HI = 9;
  localparam int LT_ATTEMPT_LO = 8;
  localparam int LT_THRESH_HI = 5;
  localparam int LT_THRESH_LO = 4;
  localparam int LT_BREAK_EN = 3;
  localparam int LT_POWER_OPT_OFF = 2;
  localparam int LT_LOGIC_RESET = 0;
  // Mode control field positions
  localparam int FM_ED_SHORT = 15;
  localparam int FM_TEN_FAST = 14;
  localparam int FM_ED_PD_EN = 13;
  localparam int FM_PD_PULSE = 12;
  localparam int FM_SPEED_OPT_EN = 7;
  localparam int FM_NEXT_PAGE = 6;
  localparam int FM_XOVER_OFF = 5;
  // Reset values
  localparam logic [1:0] ATTEMPT_RESET = 2'h0;
  localparam logic [1:0] THRESH_RESET = 2'h2;
  localparam logic NEXT_PAGE_RESET = 1'b1;
  // Attempt count per code
  localparam logic [3:0] ATTEMPTS_00 = 4'h7;
  localparam logic [3:0] ATTEMPTS_01 = 4'h5;
  localparam logic [3:0] ATTEMPTS_10 = 4'h4;
  localparam logic [3:0] ATTEMPTS_11 = 4'h3;
  typedef enum logic [1:0] {THRESH_E8, THRESH_E9, THRESH_E10, THRESH_E11} threshold_t;
endpackage : link_mode_pkg

//--- hdl/link_mode_if.sv
// Interface carrying mode codes from the register bank to the control decoder and decoded settings back
interface link_mode_if;
  logic [1:0] attempt_code;
  logic [1:0] threshold_code;
  logic break_enable;
  logic [3:0] attempts;
  logic break_armed;
  modport regs (output attempt_code, output threshold_code, output break_enable,
                input attempts, input break_armed);
  modport decode (input attempt_code, input threshold_code, input break_enable,
                  output attempts, output break_armed);
endinterface : link_mode_if

//--- hdl/link_mode_decode.sv
// Decoder turning link tuning codes into attempt count and armed link-break flag
module link_mode_decode
  import link_mode_pkg::*;
(
  link_mode_if.decode mode
);
  always_comb
  begin
    unique case (mode.attempt_code)
      2'b00: mode.attempts = ATTEMPTS_00;
      2'b01: mode.attempts = ATTEMPTS_01;
      2'b10: mode.attempts = ATTEMPTS_10;
      2'b11: mode.attempts = ATTEMPTS_11;
    endcase
  end
  // Threshold only matters while breaking is enabled
  assign mode.break_armed = mode.break_enable;
endmodule : link_mode_decode

//--- hdl/phy_link_mode_registers.sv
// Register bank for gigabit capability, link tuning and fast ethernet mode control
//
// The strobed register port was chosen for this implementation.
module phy_link_mode_registers
  import link_mode_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // Register port
  input wire logic [link_mode_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [link_mode_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [link_mode_pkg::DATA_W-1:0] reg_rdata,
  // Link tuning outputs
  output logic [3:0] speed_attempts,
  output link_mode_pkg::threshold_t idle_threshold,
  output logic link_break_armed,
  output logic power_opt_disable,
  output logic logic_reset_trigger,
  // Mode control outputs
  output logic energy_detect_short_mode,
  output logic ten_base_fast_mode,
  output logic energy_detect_powerdown_enable,
  output logic powerdown_pulse_select,
  output logic speed_opt_enable,
  output logic next_page_allow,
  output logic crossover_auto_off
);
  import link_mode_pkg::*;

  logic [1:0] attempt_reg;
  logic [1:0] thresh_reg;
  logic break_en_reg;
  logic logic_reset_trigger_reg;
  logic wr_lt;
  logic wr_fm;
  logic [DATA_W-1:0] lt_view;
  logic [DATA_W-1:0] fm_view;
  logic [DATA_W-1:0] rdata_next;

  link_mode_if mode_bus ();

  assign wr_lt = reg_write && (reg_addr == IDX_LINK_TUNING);
  assign wr_fm = reg_write && (reg_addr == IDX_FE_MODE);
  assign mode_bus.attempt_code = attempt_reg;
  assign mode_bus.threshold_code = thresh_reg;
  assign mode_bus.break_enable = break_en_reg;

  link_mode_decode u_decode (
    .mode(mode_bus.decode)
  );

  // Link tuning fields
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      attempt_reg <= ATTEMPT_RESET;
      thresh_reg <= THRESH_RESET;
      break_en_reg <= 1'b0;
      power_opt_disable <= 1'b0;
    end
    else if (clock_en && wr_lt)
    begin
      attempt_reg <= reg_wdata[LT_ATTEMPT_HI:LT_ATTEMPT_LO];
      thresh_reg <= reg_wdata[LT_THRESH_HI:LT_THRESH_LO];
      break_en_reg <= reg_wdata[LT_BREAK_EN];
      power_opt_disable <= reg_wdata[LT_POWER_OPT_OFF];
    end
  end

  // Logic reset: a write of one fires a one-cycle pulse; the bit is not self-clearing
  // in the register sense since it holds no readable state; writes made while clock_en is low are dropped.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      logic_reset_trigger_reg <= 1'b0;
    else if (clock_en)
      logic_reset_trigger_reg <= wr_lt && reg_wdata[LT_LOGIC_RESET];
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      logic_reset_trigger <= 1'b0;
    else if (clock_en)
      logic_reset_trigger <= logic_reset_trigger_reg;
  end

  // Mode control fields
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      energy_detect_short_mode <= 1'b0;
      ten_base_fast_mode <= 1'b0;
      energy_detect_powerdown_enable <= 1'b0;
      powerdown_pulse_select <= 1'b0;
      speed_opt_enable <= 1'b0;
      next_page_allow <= NEXT_PAGE_RESET;
      crossover_auto_off <= 1'b0;
    end
    else if (clock_en && wr_fm)
    begin
      energy_detect_short_mode <= reg_wdata[FM_ED_SHORT];
      ten_base_fast_mode <= reg_wdata[FM_TEN_FAST];
      energy_detect_powerdown_enable <= reg_wdata[FM_ED_PD_EN];
      powerdown_pulse_select <= reg_wdata[FM_PD_PULSE];
      speed_opt_enable <= reg_wdata[FM_SPEED_OPT_EN];
      next_page_allow <= reg_wdata[FM_NEXT_PAGE];
      crossover_auto_off <= reg_wdata[FM_XOVER_OFF];
    end
  end

  // Decoded link settings registered so every output leaves a flip-flop
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      speed_attempts <= ATTEMPTS_00;
      idle_threshold <= threshold_t'(THRESH_RESET);
      link_break_armed <= 1'b0;
    end
    else if (clock_en)
    begin
      speed_attempts <= mode_bus.attempts;
      idle_threshold <= threshold_t'(thresh_reg);
      link_break_armed <= mode_bus.break_armed;
    end
  end

  // Read views; reserved and logic reset positions read zero
  always_comb
  begin
    lt_view = '0;
    lt_view[LT_ATTEMPT_HI:LT_ATTEMPT_LO] = attempt_reg;
    lt_view[LT_THRESH_HI:LT_THRESH_LO] = thresh_reg;
    lt_view[LT_BREAK_EN] = break_en_reg;
    lt_view[LT_POWER_OPT_OFF] = power_opt_disable;
    fm_view = '0;
    fm_view[FM_ED_SHORT] = energy_detect_short_mode;
    fm_view[FM_TEN_FAST] = ten_base_fast_mode;
    fm_view[FM_ED_PD_EN] = energy_detect_powerdown_enable;
    fm_view[FM_PD_PULSE] = powerdown_pulse_select;
    fm_view[FM_SPEED_OPT_EN] = speed_opt_enable;
    fm_view[FM_NEXT_PAGE] = next_page_allow;
    fm_view[FM_XOVER_OFF] = crossover_auto_off;
  end

  always_comb
  begin
    rdata_next = '0;
    if (reg_read)
    begin
      if (reg_addr == IDX_CAPABILITY)
        rdata_next = CAPABILITY_VALUE;
      else if (reg_addr == IDX_LINK_TUNING)
        rdata_next = lt_view;
      else if (reg_addr == IDX_FE_MODE)
        rdata_next = fm_view;
    end
  end

  // Read data valid only in the cycle after the strobe, zero on other enabled cycles, held while clock_en is low
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= '0;
    else if (clock_en)
      reg_rdata <= rdata_next;
  end
endmodule : phy_link_mode_registers

//--- tb/phy_link_mode_registers_properties.sv
// Port-level checks for the link mode register bank
module phy_link_mode_registers_chk
  import link_mode_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // Settings
  input wire logic [3:0] speed_attempts,
  input wire logic power_opt_disable,
  input wire logic logic_reset_trigger,
  input wire logic next_page_allow
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire lt_wr = clock_en && reg_write && reg_addr == IDX_LINK_TUNING;
  wire rd_go = clock_en && reg_read;
  chk_cap_value: assert property (rd_go && reg_addr == IDX_CAPABILITY |=> reg_rdata == 16'h3000)
    else $error("capability read wrong");
  chk_rdata_idle: assert property (clock_en && !reg_read |=> reg_rdata == 16'h0000)
    else $error("read data not cleared");
  chk_lt_reserved: assert property (rd_go && reg_addr == IDX_LINK_TUNING |=> (reg_rdata & 16'hfcc3) == 16'h0000)
    else $error("link tuning reserved bits set");
  chk_three_tries: assert property (lt_wr && reg_wdata[9:8] == 2'h3 ##1 clock_en |=> speed_attempts == 4'h3)
    else $error("attempts not three");
  chk_five_tries: assert property (lt_wr && reg_wdata[9:8] == 2'h1 ##1 clock_en |=> speed_attempts == 4'h5)
    else $error("attempts not five");
  chk_logic_reset_trigger_fires: assert property (lt_wr && reg_wdata[0] ##1 clock_en |=> logic_reset_trigger)
    else $error("logic reset pulse missing");
  chk_logic_reset_trigger_cause: assert property (logic_reset_trigger |-> $past(reg_write, 2))
    else $error("logic reset pulse without write");
  chk_pwr_opt_set: assert property (lt_wr && reg_wdata[2] |=> power_opt_disable)
    else $error("power optimization not disabled");
  chk_pwr_opt_hold: assert property (!lt_wr |=> $stable(power_opt_disable))
    else $error("power optimization changed");
  chk_np_clear: assert property (clock_en && reg_write && reg_addr == IDX_FE_MODE && !reg_wdata[6]
    |=> !next_page_allow)
    else $error("next page not cleared");
endmodule : phy_link_mode_registers_chk
bind phy_link_mode_registers phy_link_mode_registers_chk chk (.*);

//--- tb/phy_link_mode_registers_tb_top.sv
// Directed register bench for the link mode register bank
module phy_link_mode_registers_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import link_mode_pkg::*;
  logic clock = 0, reset_n = 0, clock_en = 1, reg_write = 0, reg_read = 0;
  logic [4:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata;
  logic [3:0] speed_attempts;
  threshold_t idle_threshold;
  logic link_break_armed, power_opt_disable, logic_reset_trigger;
  logic [6:0] mode_bits;
  logic [3:0] att [4] = '{4'h7, 4'h5, 4'h4, 4'h3};
  int errors = 0, total_checks = 0, cycles = 0;
  phy_link_mode_registers uut (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .speed_attempts(speed_attempts), .idle_threshold(idle_threshold),
    .link_break_armed(link_break_armed), .power_opt_disable(power_opt_disable),
    .logic_reset_trigger(logic_reset_trigger), .energy_detect_short_mode(mode_bits[6]),
    .ten_base_fast_mode(mode_bits[5]), .energy_detect_powerdown_enable(mode_bits[4]),
    .powerdown_pulse_select(mode_bits[3]), .speed_opt_enable(mode_bits[2]),
    .next_page_allow(mode_bits[1]), .crossover_auto_off(mode_bits[0]));
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  task check(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask : check
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    #1 check("rdata", e, reg_rdata);
  endtask : rd
  task summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (5) @(posedge clock);
    reset_n <= 1'h1;
    rd(IDX_CAPABILITY, 16'h3000);
    rd(IDX_LINK_TUNING, 16'h0020);
    rd(IDX_FE_MODE, 16'h0040);
    check("attempts", 16'h0007, speed_attempts);
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_LINK_TUNING, {6'h3f, k[1:0], 2'h3, k[1:0], 4'hf});
      @(posedge clock);
      #1 check("logic_reset_trigger", 16'h0001, logic_reset_trigger);
      @(posedge clock);
      #1 check("logic_reset_trigger drop", 16'h0000, logic_reset_trigger);
      rd(IDX_LINK_TUNING, {6'h00, k[1:0], 2'h0, k[1:0], 4'hc});
      check("attempts", att[k], speed_attempts);
      check("threshold", k[15:0], idle_threshold);
      check("flags", 16'h0003, {link_break_armed, power_opt_disable});
    end
    wr(IDX_FE_MODE, 16'hffff);
    rd(IDX_FE_MODE, 16'hf0e0);
    check("mode", 16'h007f, mode_bits);
    wr(IDX_FE_MODE, 16'h0000);
    rd(IDX_FE_MODE, 16'h0000);
    check("mode", 16'h0000, mode_bits);
    wr(IDX_CAPABILITY, 16'h0000);
    rd(IDX_CAPABILITY, 16'h3000);
    rd(5'h1f, 16'h0000);
    // Enable low freezes state: this write must be ignored
    @(posedge clock);
    clock_en <= 1'h0;
    wr(IDX_LINK_TUNING, 16'h0000);
    @(posedge clock);
    clock_en <= 1'h1;
    rd(IDX_LINK_TUNING, 16'h033c);
    check("frozen logic_reset_trigger", 16'h0000, logic_reset_trigger);
    wr(IDX_LINK_TUNING, 16'h0000);
    rd(IDX_LINK_TUNING, 16'h0000);
    check("flags", 16'h0000, {link_break_armed, power_opt_disable});
    summarize();
  end
endmodule : phy_link_mode_registers_tb_top
